// *** hw/sfm_cmd.sv ***
// Command interpreter for the serial field meter in conversational mode.
// Assumes a UART delivers received bytes and takes bytes to send.
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "sfm_consts.svh"
module sfm_cmd
	import sfm_pkg::*;
#(
	parameter int NDIG = 8
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Received bytes
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	// Bytes to send
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	// Panel and measurement
	input wire logic conv_mode,
	input wire logic local_button,
	input wire logic panel_auto,
	input wire logic panel_positive,
	input wire logic panel_tesla,
	input wire logic [2:0] panel_channel,
	input wire logic [11:0] panel_dac,
	input wire logic [NDIG*4-1:0] disp_digits,
	input wire logic [3:0] disp_point,
	input wire logic [1:0] meas_status,
	input wire logic search_locked,
	input wire logic [11:0] search_dac,
	// Configuration out
	output logic remote,
	output logic lockout,
	output logic panel_enable,
	output logic [11:0] dac_code,
	output logic auto_mode,
	output logic vernier_enable,
	output logic positive_field,
	output logic tesla_unit,
	output logic fast_display,
	output logic [2:0] mux_channel,
	output logic search_active,
	output logic syntax_error,
	// AHB-Lite
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	typedef struct packed
	{
		sfm_state_t st;
		logic [7:0] cmd;
		logic [15:0] acc;
		logic big;
		logic had_dig;
		logic remote;
		logic lockout;
		logic [11:0] dac;
		logic auto;
		logic pos;
		logic tes;
		logic fast;
		logic [2:0] ch;
		logic search;
		logic synerr;
		logic btn_q;
	} sfm_cmd_t;

	sfm_cmd_t r;
	sfm_cmd_t next_r;
	logic send;
	logic busy;
	logic stat_rd;
	logic btn_edge;
	logic is_dig;
	logic [3:0] dval;
	logic [7:0] status_ch;
	logic blocked;

	// Status letter from the measurement state: 0 L, 1 N, 2 S, 3 W
	function automatic logic [7:0] sfm_status_letter(input logic [1:0] s);
		case (s)
			2'b00: sfm_status_letter = `SFM_CH_L;
			2'b01: sfm_status_letter = `SFM_CH_N;
			2'b10: sfm_status_letter = `SFM_CH_S;
			default: sfm_status_letter = `SFM_CH_W;
		endcase
	endfunction

	// Accumulator clipped to the DAC range
	function automatic logic [11:0] sfm_clip(input logic [15:0] v,
		input logic big);
		sfm_clip = (big || v[15:12] != 4'h0) ? `SFM_DAC_MAX : v[11:0];
	endfunction

	// ----------------------------------------
	// Parser
	// ----------------------------------------
	always_comb
	begin
		next_r = r;
		send = 1'b0;
		btn_edge = local_button && !r.btn_q;
		next_r.btn_q = local_button;
		is_dig = rx_data >= `SFM_CH_ZERO && rx_data <= `SFM_CH_NINE;
		dval = rx_data[3:0];
		blocked = r.search && (r.cmd == `SFM_CH_A || r.cmd == `SFM_CH_B
			|| r.cmd == `SFM_CH_C || r.cmd == `SFM_CH_F
			|| r.cmd == `SFM_CH_P);
		if (stat_rd)
			next_r.synerr = 1'b0;
		if (r.remote && !r.lockout && btn_edge)
			next_r.remote = 1'b0;
		if (rx_valid && conv_mode)
		begin
			case (r.st)
				SFM_IDLE:
				begin
					next_r.cmd = rx_data;
					next_r.acc = 16'h0000;
					next_r.big = 1'b0;
					next_r.had_dig = 1'b0;
					if (rx_data == `SFM_CH_ENQ)
						send = !busy;
					else if (!r.remote)
					begin
						if (rx_data == `SFM_CH_R)
						begin
							// Remote starts from what the panel showed, except the DAC, which starts at SFM_DAC_MID
							next_r.remote = 1'b1;
							next_r.dac = `SFM_DAC_MID;
							next_r.auto = panel_auto;
							next_r.pos = panel_positive;
							next_r.tes = panel_tesla;
							next_r.ch = panel_channel;
						end
						// Other messages are dropped quietly in local
					end
					else if (rx_data == `SFM_CH_L)
					begin
						next_r.remote = 1'b0;
						next_r.lockout = 1'b0;
					end
					else if (rx_data == `SFM_CH_K)
						next_r.lockout = 1'b1;
					else if (rx_data == `SFM_CH_R)
						next_r.remote = 1'b1;
					else if (rx_data == `SFM_CH_Q)
						next_r.search = 1'b0;
					else if (rx_data == `SFM_CH_B)
						next_r.st = SFM_BIN_HI;
					else if (rx_data == `SFM_CH_C
						|| rx_data == `SFM_CH_H)
						next_r.st = SFM_DEC;
					else if (rx_data == `SFM_CH_A || rx_data == `SFM_CH_F
						|| rx_data == `SFM_CH_D || rx_data == `SFM_CH_P
						|| rx_data == `SFM_CH_V)
						next_r.st = SFM_ARG;
					else
						next_r.synerr = 1'b1;
				end
				SFM_ARG:
				begin
					next_r.st = SFM_IDLE;
					if (blocked)
						next_r.st = SFM_IDLE;
					else if (r.cmd == `SFM_CH_A && rx_data[7:1] == 7'h18)
						next_r.auto = rx_data[0];
					else if (r.cmd == `SFM_CH_F && (rx_data == `SFM_CH_ZERO
						|| rx_data == `SFM_CH_MINUS))
						next_r.pos = 1'b0;
					else if (r.cmd == `SFM_CH_F && (rx_data == `SFM_CH_ONE
						|| rx_data == `SFM_CH_PLUS))
						next_r.pos = 1'b1;
					else if (r.cmd == `SFM_CH_D && rx_data[7:1] == 7'h18)
						next_r.tes = rx_data[0];
					else if (r.cmd == `SFM_CH_V && (rx_data[7:1] == 7'h18
						|| rx_data == `SFM_CH_N || rx_data == `SFM_CH_F))
						next_r.fast = rx_data == `SFM_CH_ONE
							|| rx_data == `SFM_CH_F;
					else if (r.cmd == `SFM_CH_P && rx_data >= `SFM_CH_A
						&& rx_data <= `SFM_CH_H)
						next_r.ch = rx_data[2:0] - 3'h1;
					else
						next_r.synerr = 1'b1;
				end
				SFM_DEC:
					if (is_dig)
					begin
						next_r.had_dig = 1'b1;
						next_r.acc = 16'(r.acc * 16'd10) + {12'h000, dval};
						if (r.acc > 16'd4095)
							next_r.big = 1'b1;
					end
					else if (rx_data == `SFM_CH_CR)
						next_r.st = SFM_LF;
					else
					begin
						next_r.synerr = 1'b1;
						next_r.st = SFM_FLUSH;
					end
				SFM_LF:
				begin
					next_r.st = SFM_IDLE;
					if (rx_data != `SFM_CH_LF)
						next_r.synerr = 1'b1;
					else if (blocked)
						next_r.st = SFM_IDLE;
					else if (r.cmd == `SFM_CH_C && r.had_dig)
						next_r.dac = sfm_clip(r.acc, r.big);
					else if (r.cmd == `SFM_CH_H)
					begin
						next_r.search = 1'b1;
						next_r.dac = r.had_dig ? sfm_clip(r.acc, r.big)
							: `SFM_DAC_ZERO;
					end
					else
						next_r.synerr = 1'b1;
				end
				SFM_BIN_HI:
				begin
					next_r.acc[15:8] = rx_data;
					next_r.st = SFM_BIN_LO;
				end
				SFM_BIN_LO:
				begin
					next_r.st = SFM_IDLE;
					if (!blocked)
						next_r.dac = {r.acc[11:8], rx_data};
				end
				default:
					// Skip to end of line after a bad decimal message
					if (rx_data == `SFM_CH_LF)
						next_r.st = SFM_IDLE;
			endcase
		end
		if (r.search && search_locked && !next_r.search)
			next_r.dac = search_dac;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			r <= '0;
			r.dac <= `SFM_DAC_MID;
			r.pos <= 1'b1;
		end
		else
			r <= next_r;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// In local the panel owns the configuration except fast_display and search_active; settings are kept
	always_comb
	begin
		status_ch = sfm_status_letter(meas_status);
		remote = r.remote;
		lockout = r.lockout;
		panel_enable = !r.remote;
		dac_code = r.remote ? r.dac : panel_dac;
		auto_mode = r.remote ? r.auto : panel_auto;
		vernier_enable = !auto_mode;
		positive_field = r.remote ? r.pos : panel_positive;
		tesla_unit = r.remote ? r.tes : panel_tesla;
		fast_display = r.fast;
		mux_channel = r.remote ? r.ch : panel_channel;
		search_active = r.search;
		syntax_error = r.synerr;
	end

	sfm_reply_fmt #(
		.NDIG(NDIG)
	) u_fmt (
		.clk(clk),
		.reset(reset),
		.start(send),
		.status_ch(status_ch),
		.digits(disp_digits),
		.point_pos(disp_point),
		.tesla(tesla_unit),
		.fast(r.fast),
		.busy(busy),
		.tx_data(tx_data),
		.tx_valid(tx_valid),
		.tx_ready(tx_ready)
	);

	sfm_ahb_regs u_regs (
		.clk(clk),
		.reset(reset),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.ctrl_word({24'h000000, r.fast, r.ch, r.search, r.pos, r.auto,
			r.tes}),
		.stat_word({28'h0000000, r.lockout, r.remote, r.synerr,
			r.search}),
		.dac_word({20'h00000, r.dac}),
		.sel_word({29'h0000000, r.st[2:0]}),
		.stat_rd(stat_rd)
	);
endmodule

// *** common/sfm_consts.svh ***
// Constants for the serial field meter command interpreter.
// Assumes inclusion by bare name from files on the include path.
`ifndef SFM_CONSTS_SVH
`define SFM_CONSTS_SVH

// ----------------------------------------
// Characters
// ----------------------------------------
`define SFM_CH_ENQ 8'h05
`define SFM_CH_CR 8'h0d
`define SFM_CH_LF 8'h0a
`define SFM_CH_DOT 8'h2e
`define SFM_CH_ZERO 8'h30
`define SFM_CH_NINE 8'h39
`define SFM_CH_ONE 8'h31
`define SFM_CH_PLUS 8'h2b
`define SFM_CH_MINUS 8'h2d
`define SFM_CH_A 8'h41
`define SFM_CH_B 8'h42
`define SFM_CH_C 8'h43
`define SFM_CH_D 8'h44
`define SFM_CH_F 8'h46
`define SFM_CH_H 8'h48
`define SFM_CH_K 8'h4b
`define SFM_CH_L 8'h4c
`define SFM_CH_N 8'h4e
`define SFM_CH_P 8'h50
`define SFM_CH_Q 8'h51
`define SFM_CH_R 8'h52
`define SFM_CH_S 8'h53
`define SFM_CH_T 8'h54
`define SFM_CH_V 8'h56
`define SFM_CH_W 8'h57

// ----------------------------------------
// Values and register map
// ----------------------------------------
`define SFM_DAC_MID 12'h800
`define SFM_DAC_MAX 12'hfff
`define SFM_DAC_ZERO 12'h000
`define SFM_ADDR_CTRL 4'h0
`define SFM_ADDR_STAT 4'h4
`define SFM_ADDR_DAC 4'h8
`define SFM_ADDR_SEL 4'hc
`endif

// *** common/sfm_pkg.sv ***
// Types shared by the command interpreter files.
// Assumes sfm_consts.svh sits on the include path.
package sfm_pkg;
	typedef enum logic [3:0]
	{
		SFM_IDLE = 4'b0000,
		SFM_ARG = 4'b0001,
		SFM_DEC = 4'b0010,
		SFM_LF = 4'b0011,
		SFM_BIN_HI = 4'b0100,
		SFM_BIN_LO = 4'b0101,
		SFM_FLUSH = 4'b0110
	} sfm_state_t;

	typedef enum logic [1:0]
	{
		SFM_TX_IDLE = 2'b00,
		SFM_TX_VAL = 2'b01,
		SFM_TX_CR = 2'b10,
		SFM_TX_LF = 2'b11
	} sfm_tx_state_t;
endpackage

// *** hw/sfm_ahb_regs.sv ***
// AHB-Lite slave presenting the control, status, DAC and parser-state words to software, read-only.
// Assumes a single master, word transfers, and zero wait states.
`timescale 1ns/1ps
`include "sfm_consts.svh"
module sfm_ahb_regs
	import sfm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// AHB-Lite
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Block state
	input wire logic [31:0] ctrl_word,
	input wire logic [31:0] stat_word,
	input wire logic [31:0] dac_word,
	input wire logic [31:0] sel_word,
	output logic stat_rd
);
	typedef struct packed
	{
		logic rd;
		logic hit;
		logic [3:0] addr;
		logic [31:0] rdata;
		logic strd;
	} sfm_ahb_t;

	sfm_ahb_t r;
	sfm_ahb_t next_r;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	always_comb
	begin
		next_r = r;
		next_r.strd = 1'b0;
		next_r.rd = hsel && hready && htrans[1] && !hwrite;
		next_r.addr = haddr[3:0];
		next_r.hit = haddr[31:4] == 28'h0000000;
		if (r.rd)
		begin
			// Unmapped words read as zero; writes are ignored
			if (!r.hit)
				next_r.rdata = 32'h0000_0000;
			else if (r.addr == `SFM_ADDR_CTRL)
				next_r.rdata = ctrl_word;
			else if (r.addr == `SFM_ADDR_STAT)
			begin
				next_r.rdata = stat_word;
				next_r.strd = 1'b1;
			end
			else if (r.addr == `SFM_ADDR_DAC)
				next_r.rdata = dac_word;
			else if (r.addr == `SFM_ADDR_SEL)
				next_r.rdata = sel_word;
			else
				next_r.rdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			r <= '0;
		else
			r <= next_r;
	end

	// Read data is produced in the data phase's cycle from live state
	always_comb
	begin
		hreadyout = 1'b1;
		hresp = 1'b0;
		hrdata = next_r.rdata;
		stat_rd = next_r.strd;
	end
endmodule

// *** hw/sfm_reply_fmt.sv ***
// Serialiser for the status letter and measured-value reply.
// Assumes the transmitter takes a byte when tx_valid and tx_ready meet.
`timescale 1ns/1ps
`include "sfm_consts.svh"
module sfm_reply_fmt
	import sfm_pkg::*;
#(
	parameter int NDIG = 8
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Request
	input wire logic start,
	input wire logic [7:0] status_ch,
	input wire logic [NDIG*4-1:0] digits,
	input wire logic [3:0] point_pos,
	input wire logic tesla,
	input wire logic fast,
	output logic busy,
	// Byte stream out
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready
);
	typedef struct packed
	{
		sfm_tx_state_t st;
		logic [4:0] idx;
		logic lead;
		logic [7:0] data;
		logic [NDIG*4-1:0] dig;
		logic [3:0] pt;
		logic tes;
		logic fst;
		logic dot;
	} sfm_fmt_t;

	sfm_fmt_t r;
	sfm_fmt_t next_r;
	logic [3:0] cur;
	logic [4:0] last;
	logic at_pt;
	logic [7:0] digit_ch;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// idx 0: status, then digits with the point after point_pos, then unit
	always_comb
	begin
		next_r = r;
		cur = r.dig[NDIG*4-1 -: 4];
		last = r.fst ? 5'(NDIG - 1) : 5'(NDIG);
		at_pt = (r.idx == 5'(r.pt)) || (r.idx == last);
		digit_ch = `SFM_CH_ZERO + {4'h0, cur};
		case (r.st)
			SFM_TX_IDLE:
				if (start)
				begin
					next_r.st = SFM_TX_VAL;
					next_r.idx = 5'h00;
					next_r.lead = 1'b1;
					next_r.dot = 1'b0;
					next_r.dig = digits;
					next_r.pt = point_pos;
					next_r.tes = tesla;
					next_r.fst = fast;
					next_r.data = status_ch;
				end
			SFM_TX_VAL:
				if (tx_ready)
				begin
					next_r.idx = r.idx + 5'h01;
					if (r.idx == last + 5'h01)
					begin
						next_r.st = SFM_TX_CR;
						next_r.data = `SFM_CH_CR;
					end
					else if (at_pt && !r.dot)
					begin
						// Point slot holds idx; forced before the unit
						next_r.data = `SFM_CH_DOT;
						next_r.idx = r.idx;
						next_r.dot = 1'b1;
						next_r.lead = 1'b0;
					end
					else if (r.idx == last)
						next_r.data = r.tes ? `SFM_CH_T : `SFM_CH_F;
					else
					begin
						next_r.dig = {r.dig[NDIG*4-5:0], 4'h0};
						// Leading zeros ahead of the last digit before the point go out as nothing
						if (r.lead && cur == 4'h0
							&& r.idx + 5'h01 < 5'(r.pt))
						begin
							next_r.data = 8'h80;
						end
						else
						begin
							next_r.data = digit_ch;
							next_r.lead = 1'b0;
						end
					end
				end
			SFM_TX_CR:
				if (tx_ready)
				begin
					next_r.st = SFM_TX_LF;
					next_r.data = `SFM_CH_LF;
				end
			default:
				if (tx_ready)
					next_r.st = SFM_TX_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			r <= '0;
		else
			r <= next_r;
	end

	// Suppressed zero slots (bit 7 set) are not presented to the link
	always_comb
	begin
		busy = r.st != SFM_TX_IDLE;
		tx_data = r.data;
		tx_valid = busy && !(r.st == SFM_TX_VAL && r.data[7]);
	end
endmodule

// *** tb/sfm_cmd_sva.sv ***
// Port checker for the command interpreter, bound into sfm_cmd.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "sfm_consts.svh"
module sfm_cmd_sva
(
	// Clock and reset
	input logic clk,
	input logic reset,
	// Link
	input logic [7:0] rx_data,
	input logic rx_valid,
	input logic [7:0] tx_data,
	input logic tx_valid,
	input logic tx_ready,
	// Panel
	input logic conv_mode,
	input logic local_button,
	input logic panel_auto,
	input logic [11:0] panel_dac,
	input logic [11:0] search_dac,
	// Configuration
	input logic remote,
	input logic lockout,
	input logic panel_enable,
	input logic [11:0] dac_code,
	input logic auto_mode,
	input logic vernier_enable,
	input logic search_active
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_enq_reply:
	assert property (rx_valid && conv_mode && rx_data == `SFM_CH_ENQ
		&& !tx_valid |=> tx_valid && tx_data inside
		{`SFM_CH_L, `SFM_CH_N, `SFM_CH_S, `SFM_CH_W})
		else $error("no status letter");
	a_tx_hold:
	assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("tx byte dropped");
	a_cr_lf:
	assert property (tx_valid && tx_ready && tx_data == `SFM_CH_CR
		|=> tx_valid && tx_data == `SFM_CH_LF) else $error("no line feed");
	a_panel_off:
	assert property (panel_enable == !remote) else $error("panel enable");
	a_remote_mid:
	assert property ($rose(remote) |-> dac_code == `SFM_DAC_MID)
		else $error("dac not mid");
	a_local_panel:
	assert property (!remote |-> auto_mode == panel_auto
		&& dac_code == panel_dac) else $error("panel ignored");
	a_button_local:
	assert property ($rose(local_button) && remote && !lockout
		|-> ##[1:4] !remote) else $error("button ignored");
	a_button_locked:
	assert property ($rose(local_button) && remote && lockout
		|=> remote [*4]) else $error("lockout broken");
	a_vernier_off:
	assert property (vernier_enable == !auto_mode) else $error("vernier");
	a_search_freeze:
	assert property ($fell(search_active) |-> dac_code == $past(search_dac))
		else $error("search not frozen");
	a_conv_off:
	assert property (!conv_mode && !local_button |=> $stable(remote)
		&& $stable(search_active)) else $error("message obeyed");
endmodule

// *** tb/sfm_host.sv ***
// Host computer model: sends command bytes, collects reply bytes.
// Assumes one byte per rx_valid pulse and a ready/valid reply stream.
`timescale 1ns/1ps
module sfm_host
(
	// Clock and reset
	input logic clk,
	input logic reset,
	// Bytes to the interpreter
	output logic [7:0] rx_data = 8'h00,
	output logic rx_valid = 1'b0,
	// Bytes from the interpreter
	input logic [7:0] tx_data,
	input logic tx_valid,
	output logic tx_ready = 1'b0
);
	logic [7:0] got[$];
	logic stall = 1'b0;
	integer seed = 32'ha84b3330;

	// Random stalls check that a waiting byte is held, not lost
	always @(posedge clk)
	begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		tx_ready <= stall ? ($random(seed) % 3 != 0) : 1'b1;
	end

	task send(input logic [7:0] b);
		@(posedge clk);
		rx_data <= b;
		rx_valid <= 1'b1;
		@(posedge clk);
		rx_valid <= 1'b0;
		// A released line never shows a stale copy of the byte
		rx_data <= ~b;
	endtask
endmodule

// *** tb/sfm_cmd_test.sv ***
// Bench for the interpreter: host model on the link, AHB reads, checks.
// Assumes sfm_host.sv and sfm_cmd_sva.sv are compiled before this file.
`timescale 1ns/1ps
`include "sfm_consts.svh"
module sfm_cmd_test;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] rx_data, tx_data;
	logic rx_valid, tx_valid, tx_ready, conv_mode, local_button;
	logic panel_auto, panel_positive, panel_tesla, search_locked;
	logic [2:0] panel_channel, mux_channel, hsize;
	logic [11:0] panel_dac, search_dac, dac_code;
	logic [31:0] disp_digits, haddr, hwdata, hrdata, rd, v;
	logic [3:0] disp_point;
	logic [1:0] meas_status, htrans;
	logic remote, lockout, panel_enable, auto_mode, vernier_enable;
	logic positive_field, tesla_unit, fast_display, search_active;
	logic syntax_error, hsel, hwrite, hready, hresp;
	logic [7:0] exp_q[$];
	integer seed = 32'ha84b3330;
	integer n_mismatch = 0;
	integer tests_run = 0;
	string cmds[8] = '{"A1", "A0", "F0", "F+", "F-", "F1", "D1", "D0"};

	sfm_cmd #(.NDIG(8)) DUT (.clk, .reset, .rx_data, .rx_valid, .tx_data,
		.tx_valid, .tx_ready, .conv_mode, .local_button, .panel_auto,
		.panel_positive, .panel_tesla, .panel_channel, .panel_dac,
		.disp_digits, .disp_point, .meas_status, .search_locked,
		.search_dac, .remote, .lockout, .panel_enable, .dac_code,
		.auto_mode, .vernier_enable, .positive_field, .tesla_unit,
		.fast_display, .mux_channel, .search_active, .syntax_error, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
		.hreadyout(hready), .hresp);
	sfm_host host (.clk, .reset, .rx_data, .rx_valid, .tx_data, .tx_valid,
		.tx_ready);

	initial
		forever #2 clk = ~clk;

	// ----
	// Tasks
	// ----
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task tmo;
		n_mismatch++;
		end_sim();
	endtask

	task msg(input string s);
		for (int i = 0; i < s.len(); i++)
			host.send(s[i]);
		repeat (4) @(posedge clk);
	endtask

	task rdy;
		integer i;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (hready === 1'b1)
				break;
		end
		if (i == 20)
			tmo();
	endtask

	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'b10;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		rdy();
		rd = hrdata;
	endtask

	function automatic void mk_reply(logic [1:0] st, logic [31:0] dg,
		integer pt, logic tes, logic fst);
		logic lead;
		logic [3:0] d;
		lead = 1'b1;
		exp_q.delete();
		exp_q.push_back(st == 0 ? `SFM_CH_L : st == 1 ? `SFM_CH_N :
			st == 2 ? `SFM_CH_S : `SFM_CH_W);
		for (int i = 0; i < (fst ? 7 : 8); i++)
		begin
			d = dg[31 - 4 * i -: 4];
			lead = lead && d == 4'h0 && i < pt - 1;
			if (!lead)
				exp_q.push_back(8'h30 + 8'(d));
			if (i == pt - 1)
				exp_q.push_back(`SFM_CH_DOT);
		end
		exp_q.push_back(tes ? `SFM_CH_T : `SFM_CH_F);
		exp_q.push_back(`SFM_CH_CR);
		exp_q.push_back(`SFM_CH_LF);
	endfunction

	task reply_case(input logic [1:0] st, input logic tes, fst, stl);
		logic [31:0] dg;
		integer pt, i;
		pt = 1 + $unsigned($random(seed)) % 4;
		for (i = 0; i < 8; i++)
			dg[4 * i +: 4] = 4'($unsigned($random(seed)) % 10);
		// Leading zero to suppress when pt is above 1, non-zero digit just before the point
		dg[31 -: 4] = 4'h0;
		dg[35 - 4 * pt -: 4] = 4'(1 + $unsigned($random(seed)) % 9);
		disp_digits <= dg;
		disp_point <= 4'(pt);
		meas_status <= st;
		panel_tesla <= tes;
		host.stall = stl;
		mk_reply(st, dg, pt, tes, fst);
		host.got.delete();
		host.send(`SFM_CH_ENQ);
		for (i = 0; i < 400 && host.got.size() < exp_q.size(); i++)
			@(posedge clk);
		if (i == 400)
			tmo();
		repeat (6) @(posedge clk);
		check(host.got.size(), exp_q.size());
		foreach (exp_q[k])
			check(host.got[k], exp_q[k]);
	endtask

	task press;
		@(posedge clk);
		local_button <= 1'b1;
		repeat (4) @(posedge clk);
		local_button <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// ----
	// Sequence
	// ----
	initial
	begin
		conv_mode = 1'b1;
		local_button = 1'b0;
		panel_auto = 1'b0;
		panel_positive = 1'b1;
		panel_tesla = 1'b0;
		panel_channel = 3'h5;
		panel_dac = 12'h2a5;
		search_locked = 1'b0;
		search_dac = 12'h000;
		disp_digits = 32'h0;
		disp_point = 4'h3;
		meas_status = 2'h0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		check(remote, 0);
		check(search_active, 0);
		conv_mode <= 1'b0;
		msg("R");
		check(remote, 0);
		conv_mode <= 1'b1;
		msg("A1V1");
		check(auto_mode, 0);
		check(fast_display, 0);
		for (int k = 0; k < 6; k++)
			reply_case(2'(k), k[0], 1'b0, k[1]);
		panel_auto <= 1'b1;
		msg("R");
		check(remote, 1);
		check(dac_code, 12'h800);
		panel_auto <= 1'b0;
		panel_dac <= 12'h111;
		@(posedge clk);
		check(auto_mode, 1);
		foreach (cmds[i])
		begin
			msg(cmds[i]);
			case (cmds[i][0])
				"A": check(auto_mode, cmds[i][1] == "1");
				"F": check(positive_field, cmds[i][1] inside {"1", "+"});
				default: check(tesla_unit, cmds[i][1] == "1");
			endcase
		end
		for (int c = 0; c < 8; c++)
		begin
			msg($sformatf("P%c", 65 + c));
			check(mux_channel, c);
		end
		for (int k = 0; k < 6; k++)
		begin
			v = k == 0 ? 5000 : k == 1 ? 4096 : $unsigned($random(seed)) % 4096;
			msg($sformatf("C%0d\015\012", v));
			check(dac_code, v > 4095 ? 4095 : v);
		end
		msg("C0012\015\012");
		check(dac_code, 12);
		for (int k = 0; k < 4; k++)
		begin
			v = k == 0 ? 32'hffff : $random(seed);
			host.send(`SFM_CH_B);
			host.send(v[15:8]);
			host.send(v[7:0]);
			repeat (4) @(posedge clk);
			check(dac_code, v[11:0]);
		end
		msg("V1");
		check(fast_display, 1);
		msg("D1");
		reply_case(2'h3, 1'b1, 1'b1, 1'b1);
		msg("V0");
		msg("D0");
		// Unknown argument: dropped, flag raised, read over the bus clears it
		msg("A7");
		check(syntax_error, 1);
		check(auto_mode, 0);
		ahb(1'b0, 32'h4, 32'h0);
		check(rd[1], 1);
		@(posedge clk);
		check(syntax_error, 0);
		ahb(1'b1, 32'h8, 32'h5);
		ahb(1'b0, 32'h8, 32'h0);
		check(rd, {20'h0, v[11:0]});
		ahb(1'b0, 32'h20, 32'h0);
		check(rd, 0);
		check(hresp, 0);
		search_locked <= 1'b1;
		search_dac <= 12'd100;
		msg("H100\015\012");
		check(search_active, 1);
		check(dac_code, 100);
		msg("A1");
		msg("PC");
		msg("F0");
		msg("C5\015\012");
		check(auto_mode, 0);
		check(mux_channel, 7);
		check(positive_field, 1);
		search_dac <= 12'h3a7;
		msg("Q");
		check(search_active, 0);
		check(dac_code, 12'h3a7);
		search_dac <= 12'h000;
		msg("Q");
		check(dac_code, 12'h3a7);
		msg("H\015\012");
		check(dac_code, 0);
		msg("Q");
		msg("K");
		check(lockout, 1);
		press();
		check(remote, 1);
		msg("L");
		check(remote, 0);
		check(dac_code, 12'h111);
		msg("R");
		press();
		check(remote, 0);
		end_sim();
	end
endmodule

bind sfm_cmd sfm_cmd_sva u_sva (.clk, .reset, .rx_data, .rx_valid,
	.tx_data, .tx_valid, .tx_ready, .conv_mode, .local_button,
	.panel_auto, .panel_dac, .search_dac, .remote, .lockout,
	.panel_enable, .dac_code, .auto_mode, .vernier_enable,
	.search_active);
